// [tpm_pkg.sv]
// Purpose: constants and types for the tap position / motor pulse controller
// Assumes: 250 MHz core_clk; times given in microseconds
// Notes:   shared by the controller top and its position decoder
//
// Behaviour
// (R1) monitoring set Off raises no event and blocks no direction
// (R2) auto-only blocking stops automatic changes in that direction, manual passes
// (R3) auto-and-manual blocking refuses both kinds in the blocked direction
// (R4) monitoring event waits until the limit condition persists for the delay
// (R5) operations counter counts each completed change; software may preload it
// (R6) digital position decoded as bcd, binary, gray or one-contact-per-position
// (R7) analog minimum and maximum levels map to two configured tap positions
// (R8) resistor series calibration walks five stages with operator confirmations
// (R9) target operation steps raise or lower until position equals target
// (R10) target permission depends on option and mode; manual local always blocked
// (R11) pulse type selects continuous or time-controlled raise/lower drive
// (R12) continuous: auto holds until in band, manual holds while key is held
// (R13) follower continuous pulse ends on runtime, motor-running fall, or master tap
// (R14) a pause follows every pulse before any further pulse
// (R15) timed pulse ends on time expiry, motor running, or position change
// (R16) no new pulse until the full pause has elapsed
// (R17) motor-running is timed against the runtime limit
// (R18) analog position interpolated linearly and rounded to nearest tap
// (R19) raise and lower never together, never a pulse while one is active
package tpm_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYC      = TICK_US * CLK_MHZ;
  localparam logic [1:0]  FMT_BCD       = 2'h0;
  localparam logic [1:0]  FMT_BIN       = 2'h1;
  localparam logic [1:0]  FMT_GRAY      = 2'h2;
  localparam logic [1:0]  FMT_ONEHOT    = 2'h3;
  localparam logic [1:0]  SRC_DIGITAL   = 2'h0;
  localparam logic [1:0]  SRC_CURRENT   = 2'h1;
  localparam logic [1:0]  SRC_RESISTOR  = 2'h2;
  localparam logic [31:0] OPS_RESET     = 32'h0000_0000;

  typedef enum logic [2:0] {
    TPM_MON_OFF    = 3'b000,
    TPM_MON_AUTO_P = 3'b001,
    TPM_MON_AUTO_M = 3'b010,
    TPM_MON_ALL_P  = 3'b011,
    TPM_MON_ALL_M  = 3'b100
  } tpm_mon_t;

  typedef enum logic [1:0] {
    TPM_TGT_AUTO = 2'b00,
    TPM_TGT_MAN  = 2'b01,
    TPM_TGT_BOTH = 2'b10
  } tpm_tgt_opt_t;

  typedef enum logic [1:0] {
    TPM_IDLE  = 2'b00,
    TPM_PULSE = 2'b01,
    TPM_PAUSE = 2'b10
  } tpm_pst_t;

  typedef enum logic [2:0] {
    TPM_CAL_IDLE = 3'b000,
    TPM_CAL_HIGH = 3'b001,
    TPM_CAL_GAIN = 3'b010,
    TPM_CAL_LOW  = 3'b011,
    TPM_CAL_OFFS = 3'b100,
    TPM_CAL_DONE = 3'b101
  } tpm_cal_t;
endpackage : tpm_pkg

// [tpm_pos_if.sv]
// Purpose: carries capture settings in and decoded position out
// Assumes: one clock; decoder is combinational toward the top
// Notes:   modports for the controller and the decoder
`timescale 1ns/1ps
`default_nettype none
interface tpm_pos_if #(parameter int PW = 8, parameter int DW = 16);
  logic [1:0]      src;
  logic [1:0]      fmt;
  logic [DW-1:0]   dig;
  logic [11:0]     ana;
  logic [11:0]     ana_lo;
  logic [11:0]     ana_hi;
  logic [PW-1:0]   pos_lo;
  logic [PW-1:0]   pos_hi;
  logic [PW-1:0]   pos;
  modport ctl (output src, fmt, dig, ana, ana_lo, ana_hi, pos_lo, pos_hi,
               input pos);
  modport dec (input src, fmt, dig, ana, ana_lo, ana_hi, pos_lo, pos_hi,
               output pos);
endinterface : tpm_pos_if
`default_nettype wire

// [tpm_pos_decode.sv]
// Purpose: turns captured inputs into a tap position
// Assumes: digital and analog inputs already sampled in core_clk
// Notes:   combinational; the top registers the result
`timescale 1ns/1ps
`default_nettype none
module tpm_pos_decode
  import tpm_pkg::*;
#(
  parameter int PW = 8,
  parameter int DW = 16
) (
  tpm_pos_if.dec p
);
  logic [PW-1:0] gray_v;
  logic [PW-1:0] bcd_v;
  logic [PW-1:0] hot_v;
  logic [PW-1:0] ana_v;
  logic [12:0]   span;
  logic [12:0]   rel;
  logic [PW:0]   pdiff;
  logic [PW+12:0] prod;
  logic [PW+12:0] quo;

  // gray to binary, one xor chain per bit
  genvar g;
  generate
    for (g = 0; g < PW; g++) begin : g_gray
      assign gray_v[g] = ^p.dig[PW-1:g];
    end
  endgenerate

  // two bcd digits, then one-contact series as index of lowest set bit
  always_comb begin
    bcd_v = PW'(p.dig[7:4]) * PW'(4'hA) + PW'(p.dig[3:0]);
    hot_v = '0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (p.dig[i]) hot_v = PW'(i);
    end
  end

  // linear interpolation rounded to nearest tap [R7] [R18]
  always_comb begin
    span  = {1'b0, p.ana_hi} - {1'b0, p.ana_lo};
    rel   = (p.ana > p.ana_lo) ? {1'b0, p.ana} - {1'b0, p.ana_lo} : '0;
    if (rel > span) rel = span;
    pdiff = {1'b0, p.pos_hi} - {1'b0, p.pos_lo};
    prod  = (PW+13)'(pdiff) * (PW+13)'(rel) + (PW+13)'(span >> 1);
    quo   = (span == '0) ? '0 : prod / (PW+13)'(span);
    ana_v = PW'(p.pos_lo + PW'(quo));
  end

  // format select [R6]
  always_comb begin
    if (p.src != SRC_DIGITAL) p.pos = ana_v;
    else begin
      unique case (p.fmt)
        FMT_BCD:    p.pos = bcd_v;
        FMT_BIN:    p.pos = p.dig[PW-1:0];
        FMT_GRAY:   p.pos = gray_v;
        FMT_ONEHOT: p.pos = hot_v;
      endcase
    end
  end

  // widths the decoder cannot serve are refused at elaboration
  if (DW < PW || PW < 8) begin : g_bad_width
    $error("tpm_pos_decode: bad widths");
  end
endmodule : tpm_pos_decode
`default_nettype wire

// [tpm_ctrl.sv]
// Purpose: tap position capture, monitoring, counting and raise/lower pulses
// Assumes: all inputs synchronous to core_clk; times in microseconds
// Notes:   one microsecond tick drives every timer
`timescale 1ns/1ps
`default_nettype none
module tpm_ctrl
  import tpm_pkg::*;
#(
  parameter int PW = 8,
  parameter int DW = 16,
  parameter int TW = 24
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic [1:0]    cap_src,
  input  wire logic [1:0]    dig_fmt,
  input  wire logic [DW-1:0] dig_in,
  input  wire logic [11:0]   ana_in,
  input  wire logic [11:0]   ana_lo_lvl,
  input  wire logic [11:0]   ana_hi_lvl,
  input  wire logic [PW-1:0] pos_at_min,
  input  wire logic [PW-1:0] pos_at_max,
  input  wire logic          cal_start,
  input  wire logic          cal_next,
  input  wire logic          cal_step_done,
  input  wire tpm_mon_t      mon_mode,
  input  wire logic [TW-1:0] mon_delay_us,
  input  wire logic          limit_hi,
  input  wire logic          limit_lo,
  input  wire logic          ops_load,
  input  wire logic [31:0]   ops_load_val,
  input  wire logic          auto_mode,
  input  wire logic          remote,
  input  wire logic          tgt_en,
  input  wire tpm_tgt_opt_t  tgt_opt,
  input  wire logic [PW-1:0] tgt_pos,
  input  wire logic          auto_raise,
  input  wire logic          auto_lower,
  input  wire logic          key_raise,
  input  wire logic          key_lower,
  input  wire logic          in_band,
  input  wire logic          follower,
  input  wire logic [PW-1:0] master_pos,
  input  wire logic          pulse_timed,
  input  wire logic [TW-1:0] pulse_time_us,
  input  wire logic [TW-1:0] pause_time_us,
  input  wire logic [TW-1:0] runtime_us,
  input  wire logic          motor_running,
  output logic               raise_out,
  output logic               lower_out,
  output logic [PW-1:0]      tap_pos,
  output logic [31:0]        ops_count,
  output logic               mon_event,
  output logic               runtime_exceeded,
  output tpm_cal_t           cal_stage,
  output logic               tgt_reached
);
  typedef struct packed {
    logic [7:0]    tick_cnt;
    logic [PW-1:0] pos;
    logic [31:0]   ops;
    logic [TW-1:0] mon_cnt;
    logic          mon_ev;
    tpm_pst_t      pst;
    logic          dir_up;
    logic [TW-1:0] ptm;
    logic [TW-1:0] rtm;
    logic          run_d;
    logic          rt_ex;
    logic          ran;
    tpm_cal_t      cal;
    logic          raise;
    logic          lower;
    logic          tgt_ok;
  } tpm_st_t;

  tpm_st_t st_r, st_nxt;
  tpm_pos_if #(.PW(PW), .DW(DW)) pif ();
  logic tick, lim, blk_up_a, blk_dn_a, blk_up_m, blk_dn_m, permit;
  logic want_up, want_dn, man_req, end_pulse;

  assign pif.src    = cap_src;
  assign pif.fmt    = dig_fmt;
  assign pif.dig    = dig_in;
  assign pif.ana    = ana_in;
  assign pif.ana_lo = ana_lo_lvl;
  assign pif.ana_hi = ana_hi_lvl;
  assign pif.pos_lo = pos_at_min;
  assign pif.pos_hi = pos_at_max;

  tpm_pos_decode #(.PW(PW), .DW(DW)) u_dec (.p(pif.dec));

  // direction blocking from the delayed monitoring event [R1] [R2] [R3]
  always_comb begin
    lim      = (mon_mode != TPM_MON_OFF) && (limit_hi || limit_lo);
    blk_up_a = st_r.mon_ev && (mon_mode == TPM_MON_AUTO_P ||
                               mon_mode == TPM_MON_ALL_P);
    blk_dn_a = st_r.mon_ev && (mon_mode == TPM_MON_AUTO_M ||
                               mon_mode == TPM_MON_ALL_M);
    blk_up_m = st_r.mon_ev && mon_mode == TPM_MON_ALL_P;
    blk_dn_m = st_r.mon_ev && mon_mode == TPM_MON_ALL_M;
  end

  // target permission table; manual local never permitted [R10]
  always_comb begin
    unique case (tgt_opt)
      TPM_TGT_AUTO: permit = auto_mode;
      TPM_TGT_MAN:  permit = !auto_mode && remote;
      TPM_TGT_BOTH: permit = auto_mode || remote;
      default:      permit = 1'b0;
    endcase
  end

  // request selection; target overrides regulator in automatic drive [R9]
  always_comb begin
    man_req = !auto_mode && (key_raise || key_lower);
    if (tgt_en && permit && st_r.pos != tgt_pos) begin
      want_up = tgt_pos > st_r.pos;
      want_dn = tgt_pos < st_r.pos;
      if (!auto_mode) begin
        want_up = want_up && !blk_up_m;
        want_dn = want_dn && !blk_dn_m;
      end else begin
        want_up = want_up && !blk_up_a;
        want_dn = want_dn && !blk_dn_a;
      end
    end else if (auto_mode) begin
      want_up = auto_raise && !auto_lower && !blk_up_a;  // [R2] [R3]
      want_dn = auto_lower && !auto_raise && !blk_dn_a;
    end else begin
      want_up = key_raise && !key_lower && !blk_up_m;    // [R2] [R3]
      want_dn = key_lower && !key_raise && !blk_dn_m;
    end
  end

  // pulse end conditions per type [R12] [R13] [R15]
  always_comb begin
    if (pulse_timed)
      end_pulse = (st_r.ptm >= pulse_time_us) || motor_running ||
                  (pif.pos != st_r.pos);
    else if (follower)
      end_pulse = st_r.rt_ex || (st_r.run_d && !motor_running) ||
                  (st_r.pos == master_pos);
    else if (tgt_en && permit)
      end_pulse = st_r.pos == tgt_pos;
    else if (auto_mode)
      end_pulse = in_band;
    else
      end_pulse = st_r.dir_up ? !key_raise : !key_lower;
  end

  // next state of the whole controller
  always_comb begin
    st_nxt = st_r;
    tick   = st_r.tick_cnt == 8'(TICK_CYC - 1);
    st_nxt.tick_cnt = tick ? 8'h00 : st_r.tick_cnt + 8'h01;
    st_nxt.pos = pif.pos;
    st_nxt.run_d = motor_running;
    st_nxt.tgt_ok = tgt_en && permit && st_r.pos == tgt_pos;
    // held-off monitoring event [R4] [R1]
    if (!lim) begin
      st_nxt.mon_cnt = '0;
      st_nxt.mon_ev  = 1'b0;
    end else if (st_r.mon_cnt >= mon_delay_us) st_nxt.mon_ev = 1'b1;
    else if (tick) st_nxt.mon_cnt = st_r.mon_cnt + 1'b1;
    // runtime supervision of the motor-running signal [R17]
    if (!motor_running) st_nxt.rtm = '0;
    else if (tick && st_r.rtm != '1) st_nxt.rtm = st_r.rtm + 1'b1;
    st_nxt.rt_ex = motor_running && st_r.rtm >= runtime_us;
    // completed change counted at end of motor run [R5]
    if (motor_running) st_nxt.ran = 1'b1;
    if (ops_load) st_nxt.ops = ops_load_val;
    else if (st_r.ran && !motor_running) begin
      st_nxt.ops = st_r.ops + 32'h0000_0001;
      st_nxt.ran = 1'b0;
    end
    // pulse sequencer: idle, pulse, pause [R11] [R14] [R16] [R19]
    unique case (st_r.pst)
      TPM_IDLE: if (want_up || want_dn) begin
        st_nxt.pst    = TPM_PULSE;
        st_nxt.dir_up = want_up;
        st_nxt.raise  = want_up;            // [R19]
        st_nxt.lower  = !want_up;
        st_nxt.ptm    = '0;
      end
      TPM_PULSE: if (end_pulse || (!man_req && !auto_mode && !tgt_en &&
                                   !pulse_timed)) begin
        st_nxt.pst   = TPM_PAUSE;
        st_nxt.raise = 1'b0;
        st_nxt.lower = 1'b0;
        st_nxt.ptm   = '0;
      end else if (tick) st_nxt.ptm = st_r.ptm + 1'b1;
      TPM_PAUSE: if (st_r.ptm >= pause_time_us) st_nxt.pst = TPM_IDLE;
        else if (tick) st_nxt.ptm = st_r.ptm + 1'b1;  // [R16]
      default: st_nxt.pst = TPM_IDLE;
    endcase
    // resistor series calibration stages [R8]
    unique case (st_r.cal)
      TPM_CAL_IDLE: if (cal_start) st_nxt.cal = TPM_CAL_HIGH;
      TPM_CAL_HIGH: if (cal_next) st_nxt.cal = TPM_CAL_GAIN;
      TPM_CAL_GAIN: if (cal_step_done) st_nxt.cal = TPM_CAL_LOW;
      TPM_CAL_LOW:  if (cal_next) st_nxt.cal = TPM_CAL_OFFS;
      TPM_CAL_OFFS: if (cal_step_done) st_nxt.cal = TPM_CAL_DONE;
      TPM_CAL_DONE: if (cal_next) st_nxt.cal = TPM_CAL_IDLE;
      default:      st_nxt.cal = TPM_CAL_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r     <= '0;
      st_r.ops <= OPS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign raise_out        = st_r.raise;
  assign lower_out        = st_r.lower;
  assign tap_pos          = st_r.pos;
  assign ops_count        = st_r.ops;
  assign mon_event        = st_r.mon_ev;
  assign runtime_exceeded = st_r.rt_ex;
  assign cal_stage        = st_r.cal;
  assign tgt_reached      = st_r.tgt_ok;

  // widths the timers and decoder cannot serve are refused at elaboration
  if (TW < 8 || PW < 8 || DW < PW) begin : g_bad_width
    $error("tpm_ctrl: bad widths");
  end

  sequence pulse_seen_s;
    st_r.raise || st_r.lower;
  endsequence
  sequence pulse_gone_s;
    !st_r.raise && !st_r.lower;
  endsequence

  excl_out_a: assert property (@(posedge core_clk) disable iff (rst) // [R19]
    !(raise_out && lower_out)) else $error("raise and lower together");
  pause_kept_a: assert property (@(posedge core_clk) disable iff (rst) // [R14]
    pulse_seen_s ##1 pulse_gone_s |-> ##1 pulse_gone_s)
    else $error("pulse restarted without pause");
  mon_off_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    mon_mode == TPM_MON_OFF |=> !mon_event) else $error("event while off");
  hold_off_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    $rose(mon_event) |-> $past(st_r.mon_cnt) >= $past(mon_delay_us))
    else $error("event before delay");
  ops_step_a: assert property (@(posedge core_clk) disable iff (rst) // [R5]
    !ops_load && st_r.ran && !motor_running |=> ops_count == $past(ops_count) + 1)
    else $error("counter missed a change");
  ops_load_a: assert property (@(posedge core_clk) disable iff (rst) // [R5]
    ops_load |=> ops_count == $past(ops_load_val)) else $error("preload lost");
  blk_all_a: assert property (@(posedge core_clk) disable iff (rst) // [R3]
    st_r.pst == TPM_IDLE && blk_up_m |=> !$rose(raise_out))
    else $error("blocked raise issued");
  blk_auto_a: assert property (@(posedge core_clk) disable iff (rst) // [R2]
    st_r.pst == TPM_IDLE && blk_dn_a && auto_mode |=> !$rose(lower_out))
    else $error("blocked auto lower issued");
  man_local_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
    !auto_mode && !remote |-> !permit) else $error("manual local permitted");
  timed_end_a: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    pulse_timed && st_r.pst == TPM_PULSE && motor_running |=> pulse_gone_s)
    else $error("timed pulse held on motor run");
  cal_flow_a: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    st_r.cal == TPM_CAL_HIGH && cal_next |=> cal_stage == TPM_CAL_GAIN)
    else $error("calibration did not advance");
endmodule : tpm_ctrl
`default_nettype wire

// [tpm_mdu_model.sv]
// Purpose: behavioural motor-drive unit facing the raise/lower outputs
// Assumes: one step per pulse edge; resp_dly of zero means never answer
// Notes:   position leaves on dig_in in the format the bench selects
`timescale 1ns/1ps
`default_nettype none
module tpm_mdu_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        raise_out,
  input  wire logic        lower_out,
  input  wire logic [15:0] resp_dly,
  input  wire logic [15:0] run_len,
  input  wire logic        preset_en,
  input  wire logic [7:0]  preset_val,
  input  wire logic [1:0]  fmt,
  output logic      [15:0] dig_in,
  output logic             motor_running
);
  int   pos_r;
  int   cnt_r;
  int   dir_r;
  logic busy_r;
  logic prev_r;
  // start only on a pulse edge, else a held pulse would step twice
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pos_r <= 5;
      cnt_r <= 0;
      dir_r <= 0;
      busy_r <= 1'b0;
      prev_r <= 1'b0;
      motor_running <= 1'b0;
    end else begin
      prev_r <= raise_out | lower_out;
      if (preset_en) begin
        pos_r <= int'(preset_val);
      end else if (!busy_r && (raise_out | lower_out) && !prev_r) begin
        busy_r <= 1'b1;
        cnt_r <= 0;
        dir_r <= raise_out ? 1 : -1;
      end else if (busy_r && resp_dly == 16'h0000) begin
        if (!(raise_out | lower_out)) busy_r <= 1'b0;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 1;
        if (cnt_r == int'(resp_dly)) motor_running <= 1'b1;
        if (cnt_r == int'(resp_dly) + int'(run_len)) begin
          motor_running <= 1'b0;
          pos_r <= pos_r + dir_r;
          busy_r <= 1'b0;
        end
      end
    end
  end
  // position coding: two bcd digits, binary, gray, one contact per tap
  always_comb begin
    case (fmt)
      2'h0:    dig_in = 16'((pos_r / 10) * 16 + pos_r % 10);
      2'h1:    dig_in = 16'(pos_r);
      2'h2:    dig_in = 16'(pos_r ^ (pos_r >> 1));
      default: dig_in = 16'h0001 << pos_r;
    endcase
  end
endmodule : tpm_mdu_model
`default_nettype wire

// [tb_top.sv]
// Purpose: self-checking bench for the tap position / pulse controller
// Assumes: tick of 250 cycles; times set to a few microseconds
// Notes:   pause and timer windows allow one tick of alignment slack
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tpm_pkg::*;
;
  logic         core_clk, rst, cal_start, cal_next, cal_step_done;
  logic [1:0]   cap_src, dig_fmt;
  logic [15:0]  dig_in, resp_dly, run_len;
  logic [11:0]  ana_in, ana_lo_lvl, ana_hi_lvl;
  logic [7:0]   pos_at_min, pos_at_max, tgt_pos, master_pos, tap_pos, pv;
  logic         limit_hi, limit_lo, ops_load, auto_mode, remote, tgt_en;
  logic         auto_raise, auto_lower, key_raise, key_lower, in_band;
  logic         follower, pulse_timed, motor_running, preset_en;
  logic         raise_out, lower_out, mon_event, runtime_exceeded;
  logic         tgt_reached, up, perm;
  logic [23:0]  mon_delay_us, pulse_time_us, pause_time_us, runtime_us;
  logic [31:0]  ops_load_val, ops_count;
  tpm_mon_t     mon_mode;
  tpm_tgt_opt_t tgt_opt;
  tpm_cal_t     cal_stage;
  int           err_total, samples_checked, exp_pos, exp_ops, n, a;
  tpm_mon_t     mt [5] = '{TPM_MON_OFF, TPM_MON_AUTO_P, TPM_MON_ALL_P,
                           TPM_MON_AUTO_M, TPM_MON_ALL_M};
  int           av [4];

  tpm_ctrl #(.PW(8), .DW(16), .TW(24)) tpm_ctrl_inst (.*);
  tpm_mdu_model tpm_mdu_model_inst (.core_clk(core_clk), .rst(rst),
    .raise_out(raise_out), .lower_out(lower_out), .resp_dly(resp_dly),
    .run_len(run_len), .preset_en(preset_en), .preset_val(pv),
    .fmt(dig_fmt), .dig_in(dig_in), .motor_running(motor_running));

  // free-running 4 ns clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // both directions at once is never legal
  always @(posedge core_clk) begin
    if (!rst) chk(32'(raise_out & lower_out), 32'h0000_0000);
  end

  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  function automatic logic sig(input int s);
    case (s)
      0:       return raise_out | lower_out;
      1:       return runtime_exceeded;
      2:       return mon_event;
      default: return motor_running;
    endcase
  endfunction : sig
  // bounded wait; c is -1 when the bound ran out
  task automatic wait_for(input int s, input logic w, input int b,
                          output int c);
    c = 0;
    while (sig(s) !== w && c < b) begin
      tick(1);
      c++;
    end
    if (sig(s) !== w) c = -1;
  endtask : wait_for
  task automatic need(input int c);
    if (c < 0) begin
      err_total++;
      summarize();
    end
  endtask : need
  task automatic settle;
    tick(840);
    chk(32'(tap_pos), 32'(exp_pos));
    chk(ops_count, 32'(exp_ops));
  endtask : settle
  task automatic preset(input logic [7:0] p);
    pv = p;
    preset_en = 1'b1;
    tick(1);
    preset_en = 1'b0;
    tick(3);
  endtask : preset
  // one request; a granted pulse is followed through to the pause end
  task automatic move(input logic u, input logic aut, input logic exp);
    int c;
    auto_mode = aut;
    if (aut) {auto_raise, auto_lower} = {u, !u};
    else {key_raise, key_lower} = {u, !u};
    wait_for(0, 1'b1, 8, c);
    chk(32'(c >= 0), 32'(exp));
    {auto_raise, auto_lower, key_raise, key_lower} = 4'h0;
    if (c >= 0) begin
      chk(32'(u ? raise_out : lower_out), 32'h0000_0001);
      wait_for(0, 1'b0, 800, c);
      need(c);
      exp_pos += u ? 1 : -1;
      exp_ops++;
    end
    settle();
  endtask : move

  initial begin
    {cal_start, cal_next, cal_step_done, limit_hi, limit_lo} = 0;
    {ops_load, remote, tgt_en, auto_raise, auto_lower, key_raise} = 0;
    {key_lower, follower, pulse_timed, preset_en, ops_load_val} = 0;
    {cap_src, ana_in, ana_lo_lvl, ana_hi_lvl, pos_at_min, pos_at_max} = 0;
    {tgt_pos, master_pos, pv, mon_delay_us, runtime_us} = 0;
    {in_band, auto_mode, dig_fmt} = {2'h3, 2'h1};
    mon_mode = TPM_MON_OFF;
    tgt_opt = TPM_TGT_AUTO;
    {pulse_time_us, pause_time_us} = {24'h00_0002, 24'h00_0002};
    {resp_dly, run_len} = {16'h0005, 16'h0014};
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    void'($urandom(32'h0f9f_56e3));
    repeat (4) @(posedge core_clk);
    chk(32'({raise_out, lower_out, mon_event}), 32'h0000_0000);
    chk(ops_count, OPS_RESET);
    #1 rst = 1'b0;
    tick(2);
    // preload of the operations counter
    ops_load_val = $urandom;
    ops_load = 1'b1;
    tick(1);
    ops_load = 1'b0;
    tick(2);
    chk(ops_count, ops_load_val);
    exp_ops = int'(ops_load_val);
    // calibration walk: operator next, device step done, back to idle
    cal_start = 1'b1;
    tick(1);
    cal_start = 1'b0;
    for (int s = 1; s < 7; s++) begin
      tick(1);
      chk(32'(cal_stage), 32'(s % 6));
      {cal_next, cal_step_done} = (s % 2) ? 2'b10 : 2'b01;
      tick(1);
      {cal_next, cal_step_done} = 2'b00;
    end
    // each digital format with a random tap
    for (int f = 0; f < 4; f++) begin
      dig_fmt = 2'(f);
      preset(8'($urandom_range(15, 0)));
      chk(32'(tap_pos), 32'(pv));
    end
    dig_fmt = FMT_BIN;
    preset(8'h05);
    exp_pos = 5;
    // analog endpoints and interior points, rounded to nearest
    {cap_src, ana_lo_lvl, ana_hi_lvl} = {SRC_CURRENT, 12'h064, 12'h44c};
    {pos_at_min, pos_at_max} = {8'h02, 8'h0c};
    av = '{100, 1100, 0, 0};
    for (int i = 0; i < 4; i++) begin
      a = i < 2 ? av[i] : $urandom_range(1100, 100);
      if ((a - 100) % 100 == 50) a++;
      ana_in = 12'(a);
      if (i == 3) cap_src = SRC_RESISTOR;
      tick(3);
      chk(32'(tap_pos), 32'(2 + ((a - 100) * 20 + 1000) / 2000));
    end
    cap_src = SRC_DIGITAL;
    tick(3);
    // manual continuous pulse, then a request inside the pause
    {auto_mode, key_raise} = 2'b01;
    wait_for(0, 1'b1, 8, n);
    need(n);
    tick(20);
    chk(32'(raise_out), 32'h0000_0001);
    key_raise = 1'b0;
    wait_for(0, 1'b0, 4, n);
    chk(32'(n >= 0), 32'h0000_0001);
    tick(100);
    key_raise = 1'b1;
    wait_for(0, 1'b1, 800, n);
    chk(32'(n >= 150 && n <= 655), 32'h0000_0001);
    key_raise = 1'b0;
    exp_pos += 2;
    exp_ops += 2;
    settle();
    // timed pulse with a silent drive runs its full time
    {pulse_timed, resp_dly, key_raise} = {1'b1, 16'h0000, 1'b1};
    wait_for(0, 1'b1, 8, n);
    need(n);
    key_raise = 1'b0;
    wait_for(0, 1'b0, 900, n);
    chk(32'(n >= 240 && n <= 760), 32'h0000_0001);
    tick(840);
    // long motor run against a one-microsecond limit
    {resp_dly, run_len, runtime_us} = {16'h0003, 16'h0190, 24'h00_0001};
    key_raise = 1'b1;
    wait_for(0, 1'b1, 8, n);
    need(n);
    key_raise = 1'b0;
    wait_for(1, 1'b1, 700, n);
    chk(32'(n >= 0), 32'h0000_0001);
    exp_pos++;
    exp_ops++;
    settle();
    // follower: pulse ends when motor running falls
    {resp_dly, run_len, runtime_us} = {16'h0005, 16'h0014, 24'h00_0064};
    {pulse_timed, follower, in_band, auto_mode, auto_raise} = 5'b01011;
    master_pos = 8'(exp_pos + 5);
    wait_for(3, 1'b1, 20, n);
    need(n);
    wait_for(3, 1'b0, 40, n);
    need(n);
    wait_for(0, 1'b0, 4, n);
    chk(32'(n >= 0), 32'h0000_0001);
    {auto_raise, in_band, follower} = 3'b010;
    exp_pos++;
    exp_ops++;
    settle();
    // automatic continuous pulse ends once back in band
    {in_band, auto_mode, auto_raise} = 3'b011;
    wait_for(0, 1'b1, 8, n);
    need(n);
    tick(10);
    chk(32'(raise_out), 32'h0000_0001);
    {in_band, auto_raise} = 2'b10;
    wait_for(0, 1'b0, 4, n);
    chk(32'(n >= 0), 32'h0000_0001);
    exp_pos++;
    exp_ops++;
    settle();
    // every monitoring behaviour, with its delay, auto and manual
    {pulse_timed, mon_delay_us} = {1'b1, 24'h00_0002};
    for (int i = 0; i < 5; i++) begin
      up = !(mt[i] == TPM_MON_AUTO_M || mt[i] == TPM_MON_ALL_M);
      {limit_hi, limit_lo} = {up, !up};
      mon_mode = mt[i];
      tick(2);
      chk(32'(mon_event), 32'h0000_0000);
      if (mt[i] != TPM_MON_OFF) begin
        wait_for(2, 1'b1, 900, n);
        chk(32'(n >= 240 && n <= 760), 32'h0000_0001);
      end else begin
        tick(800);
        chk(32'(mon_event), 32'h0000_0000);
      end
      move(up, 1'b1, mt[i] == TPM_MON_OFF);
      move(up, 1'b0, mt[i] == TPM_MON_OFF || mt[i] == TPM_MON_AUTO_P ||
           mt[i] == TPM_MON_AUTO_M);
      {limit_hi, limit_lo} = 2'b00;
      mon_mode = TPM_MON_OFF;
      tick(4);
    end
    // target permission over every option and mode
    pulse_timed = 1'b0;
    for (int o = 0; o < 3; o++) begin
      for (int m = 0; m < 4; m++) begin
        tgt_opt = tpm_tgt_opt_t'(o);
        {auto_mode, remote} = 2'(m);
        perm = (o == 0 && auto_mode) || (o == 1 && !auto_mode && remote) ||
               (o == 2 && (auto_mode || remote));
        {tgt_pos, tgt_en} = {8'(exp_pos + 1), 1'b1};
        wait_for(0, 1'b1, 8, n);
        chk(32'(n >= 0), 32'(perm));
        if (n >= 0) begin
          wait_for(0, 1'b0, 200, n);
          need(n);
          exp_pos++;
          exp_ops++;
          tick(40);
          chk(32'(tgt_reached), 32'h0000_0001);
        end
        tgt_en = 1'b0;
        settle();
      end
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
